// ---- hw/ospm_ctrl.v ----
`timescale 1ns/1ns
`include "ospm_defs.vh"
// Operation
// [R1] Select bits map to oscillator enables/selection
// [R2] Reset selects internal, external disabled
// [R3] Both set: external runs, internal clocks
// [R4] Software waits external stable before switching
// [R5] Read-only pending flag set by request
// [R6] Write-only acknowledge clears pending flag
// [R7] Read/write enable gates external requests
// [R8] Stop halts oscillators, keeps select bits
// [R9] Stop clears core timer flags, enables
// [R10] Stop clears programmable timer flags, enables
// [R11] Stop/wait sets enable, clears mask
// [R12] Stop changes nothing else
// [R13] Stop wakes on ext edges, vector
// [R14] Stop exit delay 16 or 4064
// [R15] Wait stops only the bus clock
// [R16] Timer interrupts end wait, vectors
// [R17] Serial and analog end wait, vectors
// [R18] Watchdog or pin reset vector reset
// [R19] Wait exit has no delay
// [R20] Halt option: wait plus recovery delay
// [R21] Halt never stops the oscillators
// [R22] Hold reset low through supply dip; no supply monitor here, chip_reset follows only pin reset and watchdog
// [R23] Glitch-free clock source change
module ospm_ctrl (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_int_n,
  input  wire [3:0]  port_a_low_pins,
  input  wire        ext_reset_n,
  input  wire        watchdog_timeout,
  input  wire        ct_int,
  input  wire        pt_int,
  input  wire        ser_int,
  input  wire        ana_int,
  output reg         int_osc_en,
  output reg         ext_osc_en,
  output reg         clk_sel_ext,
  output reg         bus_clk_en,
  output reg         periph_clk_en,
  output reg         ct_clear,
  output reg         pt_clear,
  output reg         cpu_mask_clear,
  output reg         ext_int_req,
  output reg         wake_pulse,
  output reg  [15:0] wake_vector,
  output reg         chip_reset
);
  localparam ST_RUN  = 2'b00;
  localparam ST_STOP = 2'b01;
  localparam ST_WAIT = 2'b10;
  localparam ST_REC  = 2'b11;

  // ==========================================
  // Pin synchronisers: change counts when stages 2 and 3 agree
  reg [5:0] s1_q, s2_q, s3_q, pin_q;
  wire [5:0] pin_raw = {ext_reset_n, ext_int_n, port_a_low_pins};
  wire [5:0] pin_d = (s2_q == s3_q) ? s2_q : pin_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q  <= 6'h3F;
      s2_q  <= 6'h3F;
      s3_q  <= 6'h3F;
      pin_q <= 6'h3F;
    end else if (clk_en) begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end
  wire irq_fall  = pin_q[4] & ~pin_d[4];
  wire [3:0] pa_rise = ~pin_q[3:0] & pin_d[3:0];
  wire pin_rst   = ~pin_q[5];

  // ==========================================
  // APB decode
  function sel;
    input [11:0] a;
    input [11:0] b;
    begin
      sel = (a == b);
    end
  endfunction
  wire acc  = psel & penable & ~pready;
  wire wr   = acc & pwrite;
  wire wr_c = wr & sel(paddr, `OSPM_A_IRQ_STATUS_AND_OSC_CONTROL);
  wire wr_m = wr & sel(paddr, `OSPM_A_MODE);
  wire wr_o = wr & sel(paddr, `OSPM_A_OPTION);
  wire hit  = sel(paddr, `OSPM_A_IRQ_STATUS_AND_OSC_CONTROL) | sel(paddr, `OSPM_A_MODE) |
              sel(paddr, `OSPM_A_STATUS) | sel(paddr, `OSPM_A_OPTION);

  reg  [1:0]  osc_q;
  reg         en_q, pend_q;
  reg  [2:0]  opt_q;
  reg  [1:0]  st_q;
  reg  [11:0] cnt_q;
  reg         run_ext_q;
  reg         halt_q;

  wire ext_evt  = en_q & (irq_fall | (opt_q[`OSPM_B_OPT_PORT] & (|pa_rise)));
  wire stop_cmd = wr_m & pwdata[`OSPM_B_CMD_STOP];
  wire wait_cmd = wr_m & pwdata[`OSPM_B_CMD_WAIT] & ~pwdata[`OSPM_B_CMD_STOP];
  wire halt     = opt_q[`OSPM_B_OPT_HALT];
  wire sleep_go = (st_q == ST_RUN) & (stop_cmd | wait_cmd);
  wire [11:0] dly = opt_q[`OSPM_B_OPT_DLY] ? `OSPM_DLY_LONG : `OSPM_DLY_SHORT;
  wire hard_rst = pin_rst | watchdog_timeout;

  // ==========================================
  // Control register
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_q  <= `OSPM_RST_OSC; // [R2]
      en_q   <= `OSPM_RST_EN;
      pend_q <= 1'b0;
      opt_q  <= 3'b000;
    end else if (clk_en) begin
      if (hard_rst) begin
        osc_q  <= `OSPM_RST_OSC; // [R2] [R18]
        en_q   <= `OSPM_RST_EN;
        pend_q <= 1'b0;
      end else begin
        if (wr_c) begin
          osc_q <= {pwdata[`OSPM_B_OSC_HI], pwdata[`OSPM_B_OSC_LO]};
          en_q  <= pwdata[`OSPM_B_EN]; // [R7]
        end
        if (sleep_go)
          en_q <= 1'b1; // [R11] [R12]
        // Set beats acknowledge so a same-cycle request survives
        if (ext_evt)
          pend_q <= 1'b1; // [R5]
        else if (wr_c & pwdata[`OSPM_B_ACK])
          pend_q <= 1'b0; // [R6]
      end
      if (wr_o)
        opt_q <= pwdata[2:0];
    end
  end

  // ==========================================
  // Low-power sequencer
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q           <= ST_RUN;
      cnt_q          <= 12'h000;
      wake_pulse     <= 1'b0;
      wake_vector    <= `OSPM_V_RST;
      ct_clear       <= 1'b0;
      pt_clear       <= 1'b0;
      cpu_mask_clear <= 1'b0;
      chip_reset     <= 1'b1;
      halt_q         <= 1'b0;
    end else if (clk_en) begin
      wake_pulse     <= 1'b0;
      ct_clear       <= 1'b0;
      pt_clear       <= 1'b0;
      cpu_mask_clear <= 1'b0;
      chip_reset     <= hard_rst; // [R22]
      if (hard_rst) begin
        st_q        <= ST_RUN;
        wake_vector <= `OSPM_V_RST; // [R18] [R13]
      end else begin
        case (st_q)
          ST_RUN: begin
            if (sleep_go) begin
              cpu_mask_clear <= 1'b1; // [R11]
              // Remember a halt so the wake takes the recovery path
              halt_q         <= stop_cmd & halt; // [R20]
              if (stop_cmd & ~halt) begin
                st_q     <= ST_STOP;
                ct_clear <= 1'b1; // [R9]
                pt_clear <= 1'b1; // [R10]
              end else begin
                st_q <= ST_WAIT; // [R20] [R21]
              end
            end
          end
          ST_STOP: begin
            if (ext_evt) begin
              wake_vector <= `OSPM_V_EXT; // [R13]
              cnt_q       <= dly; // [R14]
              st_q        <= ST_REC;
            end
          end
          ST_WAIT: begin
            if (ext_evt | ct_int | pt_int | ser_int | ana_int) begin
              if (ext_evt)
                wake_vector <= `OSPM_V_EXT;
              else if (ct_int)
                wake_vector <= `OSPM_V_CT; // [R16]
              else if (pt_int)
                wake_vector <= `OSPM_V_PT; // [R16]
              else if (ser_int)
                wake_vector <= `OSPM_V_SER; // [R17]
              else
                wake_vector <= `OSPM_V_ANA; // [R17]
              if (halt_q) begin
                cnt_q <= dly; // [R20]
                st_q  <= ST_REC;
              end else begin
                wake_pulse <= 1'b1; // [R19]
                st_q       <= ST_RUN;
              end
            end
          end
          ST_REC: begin
            if (cnt_q <= 12'h001) begin
              wake_pulse <= 1'b1;
              st_q       <= ST_RUN;
            end
            cnt_q <= cnt_q - 12'h001;
          end
          default: st_q <= ST_RUN;
        endcase
      end
    end
  end

  // ==========================================
  // Requested source: external only for select pattern 01
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      run_ext_q <= 1'b0;
    else if (clk_en)
      run_ext_q <= (osc_q == 2'b01); // [R4]
  end

  // ==========================================
  // Clock enables and oscillator controls
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_osc_en    <= 1'b1;
      ext_osc_en    <= 1'b0;
      clk_sel_ext   <= 1'b0;
      bus_clk_en    <= 1'b0;
      periph_clk_en <= 1'b1;
      ext_int_req   <= 1'b0;
    end else if (clk_en) begin
      int_osc_en    <= (st_q != ST_STOP) & ~(osc_q == 2'b01); // [R1] [R8]
      ext_osc_en    <= (st_q != ST_STOP) & osc_q[`OSPM_B_OSC_LO]; // [R1] [R3] [R8]
      // Source switches only while bus clock is gated, avoiding runts
      if (~bus_clk_en | (st_q != ST_RUN))
        clk_sel_ext <= run_ext_q; // [R23]
      bus_clk_en    <= (st_q == ST_RUN) & ~hard_rst & ~sleep_go &
                       (clk_sel_ext == run_ext_q); // [R15] [R23]
      periph_clk_en <= (st_q != ST_STOP); // [R8] [R15]
      ext_int_req   <= pend_q & en_q;
    end
  end

  // ==========================================
  // APB slave: one wait state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= 32'h00000000;
      if (acc & ~pwrite) begin
        if (sel(paddr, `OSPM_A_IRQ_STATUS_AND_OSC_CONTROL))
          prdata <= {27'h0, en_q, pend_q, 1'b0, osc_q}; // [R5] [R6]
        else if (sel(paddr, `OSPM_A_STATUS))
          prdata <= {28'h0, cnt_q != 12'h000, st_q, bus_clk_en};
        else if (sel(paddr, `OSPM_A_OPTION))
          prdata <= {29'h0, opt_q};
      end
    end
  end
endmodule

// ---- hw/ospm_defs.vh ----
`ifndef OSPM_DEFS_VH
`define OSPM_DEFS_VH
// ==========================================
// Register map (byte addresses)
`define OSPM_A_IRQ_STATUS_AND_OSC_CONTROL      12'h000
`define OSPM_A_MODE      12'h004
`define OSPM_A_STATUS    12'h008
`define OSPM_A_OPTION    12'h00C
// ==========================================
// Control register bit positions
`define OSPM_B_OSC_LO    0
`define OSPM_B_OSC_HI    1
`define OSPM_B_ACK       2
`define OSPM_B_PEND      3
`define OSPM_B_EN        4
// Mode register command bits
`define OSPM_B_CMD_STOP  0
`define OSPM_B_CMD_WAIT  1
// Option register bits
`define OSPM_B_OPT_DLY   0
`define OSPM_B_OPT_HALT  1
`define OSPM_B_OPT_PORT  2
// ==========================================
// Reset values
`define OSPM_RST_OSC     2'b10
`define OSPM_RST_EN      1'b1
// ==========================================
// Vectors
`define OSPM_V_EXT       16'h1FFA
`define OSPM_V_CT        16'h1FF8
`define OSPM_V_PT        16'h1FF6
`define OSPM_V_SER       16'h1FF4
`define OSPM_V_ANA       16'h1FF2
`define OSPM_V_RST       16'h1FFE
// ==========================================
// Recovery delays in bus cycles
`define OSPM_DLY_SHORT   12'h010
`define OSPM_DLY_LONG    12'hFE0
`endif

// ---- verif/ospm_sva.sv ----
`timescale 1ns/1ns
module ospm_sva (
  input logic        sys_clk,
  input logic        rst,
  input logic        watchdog_timeout,
  input logic        int_osc_en,
  input logic        ext_osc_en,
  input logic        clk_sel_ext,
  input logic        bus_clk_en,
  input logic        periph_clk_en,
  input logic        ct_clear,
  input logic        pt_clear,
  input logic        cpu_mask_clear,
  input logic        wake_pulse,
  input logic [15:0] wake_vector,
  input logic        chip_reset
);
  // ======
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rst_osc: assert property ($past(rst) |-> int_osc_en && !ext_osc_en && !clk_sel_ext)
    else $error("osc state after reset");
  a_osc_live: assert property (periph_clk_en |-> int_osc_en || ext_osc_en)
    else $error("no oscillator running");
  a_sleep_gate: assert property ($rose(cpu_mask_clear) |-> ##[0:2] !bus_clk_en)
    else $error("bus clock not gated");
  a_stop_pair: assert property (ct_clear |-> pt_clear && cpu_mask_clear)
    else $error("stop clears incomplete");
  a_stop_osc: assert property (ct_clear |-> ##[0:2] !periph_clk_en && !int_osc_en && !ext_osc_en)
    else $error("stop left a clock on");
  a_wait_run: assert property (cpu_mask_clear && !ct_clear |-> periph_clk_en [*3])
    else $error("wait stopped peripherals");
  a_wake_vec: assert property (wake_pulse |-> wake_vector inside {16'h1FFA, 16'h1FF8, 16'h1FF6, 16'h1FF4, 16'h1FF2})
    else $error("bad wake vector");
  a_wake_run: assert property (wake_pulse |-> ##[0:2] bus_clk_en)
    else $error("bus clock not restarted");
  a_wd_reset: assert property ($rose(watchdog_timeout) |-> ##[1:4] chip_reset && wake_vector == 16'h1FFE)
    else $error("watchdog reset missing");
  c_stop: cover property (ct_clear);
  c_ana: cover property (wake_pulse && wake_vector == 16'h1FF2);
  c_rst: cover property ($rose(chip_reset));
endmodule
bind ospm_ctrl ospm_sva sva_u (.*);

// ---- verif/ospm_peer.sv ----
`timescale 1ns/1ns
module ospm_peer (
  input  logic       sys_clk,
  input  logic       rst,
  input  logic [3:0] fire,
  input  logic       wake_pulse,
  output logic [3:0] irq_q
);
  // ======
  // Sources hold their level until serviced, as real flags do
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      irq_q <= 4'h0;
    else if (wake_pulse)
      irq_q <= 4'h0;
    else
      irq_q <= irq_q | fire;
  end
endmodule

// ---- verif/ospm_ctrl_tb.sv ----
`timescale 1ns/1ns
module ospm_ctrl_tb;
  // ======
  // Signals
  logic        sys_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr, ext_int_n, ext_reset_n;
  logic        watchdog_timeout, int_osc_en, ext_osc_en, clk_sel_ext, bus_clk_en, periph_clk_en;
  logic        ct_clear, pt_clear, cpu_mask_clear, ext_int_req, wake_pulse, chip_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] wake_vector;
  logic [3:0]  port_a_low_pins, fire;
  wire         ct_int, pt_int, ser_int, ana_int;
  int          n_fail, n_tests;
  localparam logic [2:0] OC [5] = '{3'h0, 3'h2, 3'h3, 3'h1, 3'h2};
  localparam logic [2:0] OX [5] = '{3'h4, 3'h4, 3'h6, 3'h3, 3'h4};
  localparam logic [2:0] OPT [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  ospm_ctrl dut_u (.*);
  ospm_peer peer_u (.sys_clk(sys_clk), .rst(rst), .fire(fire), .wake_pulse(wake_pulse),
                    .irq_q({ana_int, ser_int, pt_int, ct_int}));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ======
  // Tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic wake(output int n);
    n = 0;
    while (wake_pulse !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  // ======
  // Sequence
  initial begin
    int n, dl;
    logic [31:0] q;
    logic e;
    {psel, penable, pwrite, paddr, pwdata, fire, watchdog_timeout, port_a_low_pins} = '0;
    {ext_int_n, ext_reset_n, clk_en, rst} = 4'hF;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(12'h000, 32'h12);
    foreach (OC[i]) begin
      wr(12'h000, 32'h10 | OC[i]);
      repeat (6) @(posedge sys_clk);
      chk({int_osc_en, ext_osc_en, clk_sel_ext}, OX[i]);
    end
    apb(12'h010, 1'b0, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000);
    for (int i = 0; i < 2; i++) begin
      wr(12'h000, i ? 32'h12 : 32'h02);
      ext_int_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      ext_int_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rd(12'h000, i ? 32'h1A : 32'h02);
    end
    chk(ext_int_req, 1'b1);
    wr(12'h000, 32'h0A);
    chk(ext_int_req, 1'b0);
    wr(12'h000, 32'h16);
    rd(12'h000, 32'h12);
    wr(12'h000, 32'h1A);
    rd(12'h000, 32'h12);
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, 32'h02);
      wr(12'h004, 32'h02);
      fire <= 4'h1 << i;
      @(posedge sys_clk) fire <= 4'h0;
      wake(n);
      chk(wake_vector, 16'h1FF8 - 2 * i);
      chk(n <= 4, 1'b1);
      repeat (2) @(posedge sys_clk);
      rd(12'h000, 32'h12);
    end
    foreach (OPT[i]) begin
      dl = OPT[i][0] ? 4064 : 16;
      wr(12'h00C, OPT[i]);
      wr(12'h004, 32'h01);
      chk(periph_clk_en, OPT[i][1]);
      if (OPT[i][2]) port_a_low_pins <= 4'h8;
      else ext_int_n <= 1'b0;
      wake(n);
      chk(wake_vector, 16'h1FFA);
      chk(n >= dl && n <= dl + 8, 1'b1);
      ext_int_n <= 1'b1;
      port_a_low_pins <= 4'h0;
      wr(12'h000, 32'h16);
      rd(12'h000, 32'h12);
    end
    for (int i = 0; i < 2; i++) begin
      wr(12'h000, 32'h13);
      if (i) ext_reset_n <= 1'b0;
      else watchdog_timeout <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk({chip_reset, wake_vector}, 32'h11FFE);
      ext_reset_n <= 1'b1;
      watchdog_timeout <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rd(12'h000, 32'h12);
    end
    complete_run();
  end
endmodule
